// File: verilog/cafm_regs.sv
// Purpose: Fault mask and converter control register bank of a charger.
// Assumes: Byte register port decoded upstream from the serial host link.
// Notes:   Conversion itself is analog and outside; here only control.
`timescale 1ns/10ps
`default_nettype none
module cafm_regs (
	// Clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  reset_n,
	// Register port
	input  wire logic                  reg_wr,
	input  wire logic [7:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	output logic [7:0]                 reg_rdata,
	output logic                       reg_hit,
	// Reset sources
	input  wire logic                  reg_reset_cmd,
	input  wire logic                  watchdog_expired,
	// Fault events, one-cycle pulses
	input  wire logic                  system_short_evt,
	input  wire logic                  system_overvolt_evt,
	input  wire logic                  source_overvolt_evt,
	input  wire logic                  source_undervolt_evt,
	input  wire logic                  thermal_trip_evt,
	// Converter handshake
	input  wire logic                  conv_done_evt,
	input  wire logic                  done_irq_block,
	input  wire logic                  ibat_discharging,
	// Converter controls
	output logic                       conv_enable,
	output logic                       conv_one_shot,
	output cafm_pkg::cafm_res_t        conv_resolution,
	output logic                       running_mean_select,
	output logic                       mean_seed_select,
	output logic                       mean_apply_ibat,
	output logic [10:0]                chan_off,
	output logic [3:0]                 conv_chan,
	// Interrupt
	output logic                       irq_pulse
);
	import cafm_pkg::*;

	// ****************************************************************
	// Register state
	// ****************************************************************
	logic [7:0] fault_irq_mask_one_q;
	logic [7:0] converter_control_q;
	logic [7:0] channel_disable_zero_q;
	logic [7:0] channel_disable_one_q;
	logic       pass_done;
	logic       soft_rst;

	assign soft_rst = !reset_n || reg_reset_cmd;

	// Write strobe per register: address match only; masking to writable bits is done at each write.
	function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] o);
		return (a == o);
	endfunction

	// Fault mask: only register reset or power-on restores defaults.
	always_ff @(posedge core_clk) begin
		if (soft_rst) begin
			fault_irq_mask_one_q <= CAFM_RST_FAULT_MASK_ONE;
		end else if (reg_wr && wr_hit(reg_addr, CAFM_OFS_FAULT_MASK_ONE)) begin
			fault_irq_mask_one_q <= reg_wdata & CAFM_WMASK_FAULT_ONE;
		end
	end

	// Control. Enable also drops on watchdog and after one shot pass.
	// Register write wins over the pass end so a rearm is never lost.
	always_ff @(posedge core_clk) begin
		if (soft_rst) begin
			converter_control_q <= CAFM_RST_CONV_CTRL;
		end else if (reg_wr && wr_hit(reg_addr, CAFM_OFS_CONV_CTRL)) begin
			converter_control_q <= reg_wdata & CAFM_WMASK_CONV_CTRL;
		end else if (watchdog_expired) begin
			converter_control_q[CAFM_BIT_CONV_EN] <= 1'b0;
		end else if (pass_done && converter_control_q[CAFM_BIT_ONE_SHOT]) begin
			converter_control_q[CAFM_BIT_CONV_EN] <= 1'b0;
		end
	end

	// Channel disables, untouched by the watchdog.
	always_ff @(posedge core_clk) begin
		if (soft_rst) begin
			channel_disable_zero_q <= CAFM_RST_CHAN_DIS_ZERO;
			channel_disable_one_q  <= CAFM_RST_CHAN_DIS_ONE;
		end else if (reg_wr) begin
			if (wr_hit(reg_addr, CAFM_OFS_CHAN_DIS_ZERO)) begin
				channel_disable_zero_q <= reg_wdata & CAFM_WMASK_DIS_ZERO;
			end
			if (wr_hit(reg_addr, CAFM_OFS_CHAN_DIS_ONE)) begin
				channel_disable_one_q <= reg_wdata & CAFM_WMASK_DIS_ONE;
			end
		end
	end

	// ****************************************************************
	// Read mux; unmapped offsets read zero and drop reg_hit
	// ****************************************************************
	always_comb begin
		reg_rdata = 8'h00;
		reg_hit   = 1'b1;
		unique case (reg_addr)
			CAFM_OFS_FAULT_MASK_ONE: reg_rdata = fault_irq_mask_one_q;
			CAFM_OFS_CONV_CTRL:      reg_rdata = converter_control_q;
			CAFM_OFS_CHAN_DIS_ZERO:  reg_rdata = channel_disable_zero_q;
			CAFM_OFS_CHAN_DIS_ONE:   reg_rdata = channel_disable_one_q;
			default:                 reg_hit   = 1'b0;
		endcase
	end

	// ****************************************************************
	// Control outputs
	// ****************************************************************
	logic system_short_irq_block;
	logic system_overvolt_irq_block;
	logic source_overvolt_irq_block;
	logic source_undervolt_irq_block;
	logic thermal_trip_irq_block;

	assign system_short_irq_block     = fault_irq_mask_one_q[CAFM_BIT_SYS_SHORT];
	assign system_overvolt_irq_block  = fault_irq_mask_one_q[CAFM_BIT_SYS_OV];
	assign source_overvolt_irq_block  = fault_irq_mask_one_q[CAFM_BIT_SRC_OV];
	assign source_undervolt_irq_block = fault_irq_mask_one_q[CAFM_BIT_SRC_UV];
	assign thermal_trip_irq_block     = fault_irq_mask_one_q[CAFM_BIT_THERMAL];

	// Controls straight from flip-flops.
	assign conv_enable     = converter_control_q[CAFM_BIT_CONV_EN];
	assign conv_one_shot   = converter_control_q[CAFM_BIT_ONE_SHOT];
	assign conv_resolution = cafm_res_t'(
		converter_control_q[CAFM_BIT_SPEED_HI:CAFM_BIT_SPEED_LO]);
	assign running_mean_select = converter_control_q[CAFM_BIT_MEAN];
	assign mean_seed_select    = converter_control_q[CAFM_BIT_SEED];
	// Averaging is suppressed for the discharge current reading.
	assign mean_apply_ibat = running_mean_select && !ibat_discharging;
	assign chan_off = {channel_disable_one_q[7:CAFM_DIS1_LO],
		channel_disable_zero_q[7:CAFM_DIS0_LO]};

	// ****************************************************************
	// Channel scheduler
	// ****************************************************************
	cafm_sample_sched #(
		.NCH        (CAFM_NUM_CHANS)
	) u_sched (
		.core_clk   (core_clk),
		.reset_n    (reset_n),
		.run        (conv_enable),
		.step       (conv_done_evt),
		.chan_off   (chan_off),
		.chan_q     (conv_chan),
		.wrap_pulse (pass_done)
	);

	// ****************************************************************
	// Interrupt gate; done only counts in one-shot mode
	// ****************************************************************
	logic       done_one_shot;
	logic [5:0] evts;
	logic [5:0] blks;

	assign done_one_shot = pass_done && conv_one_shot;
	assign evts = {done_one_shot, thermal_trip_evt, source_undervolt_evt,
		source_overvolt_evt, system_overvolt_evt, system_short_evt};
	assign blks = {done_irq_block, thermal_trip_irq_block,
		source_undervolt_irq_block, source_overvolt_irq_block,
		system_overvolt_irq_block, system_short_irq_block};

	cafm_irq_gate #(
		.N           (6)
	) u_irq (
		.core_clk    (core_clk),
		.reset_n     (reset_n),
		.event_pulse (evts),
		.event_block (blks),
		.irq_pulse   (irq_pulse)
	);

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_short_unmasked: assert property (@(posedge core_clk) disable iff (!reset_n)
		system_short_evt && !system_short_irq_block |=> irq_pulse)
		else $error("unmasked system short did not pulse interrupt");
	a_sysov_unmasked: assert property (@(posedge core_clk) disable iff (!reset_n)
		system_overvolt_evt && !system_overvolt_irq_block |=> irq_pulse)
		else $error("unmasked system overvoltage did not pulse interrupt");
	a_srcov_unmasked: assert property (@(posedge core_clk) disable iff (!reset_n)
		source_overvolt_evt && !source_overvolt_irq_block |=> irq_pulse)
		else $error("unmasked source overvoltage did not pulse interrupt");
	a_srcuv_unmasked: assert property (@(posedge core_clk) disable iff (!reset_n)
		source_undervolt_evt && !source_undervolt_irq_block |=> irq_pulse)
		else $error("unmasked source undervoltage did not pulse interrupt");
	a_thermal_unmasked: assert property (@(posedge core_clk) disable iff (!reset_n)
		thermal_trip_evt && !thermal_trip_irq_block |=> irq_pulse)
		else $error("unmasked thermal trip did not pulse interrupt");
	a_irq_all_blocked: assert property (@(posedge core_clk) disable iff (!reset_n)
		(fault_irq_mask_one_q[7:4] == 4'hF) && fault_irq_mask_one_q[2] &&
		done_irq_block |=> !irq_pulse)
		else $error("interrupt pulsed with every source blocked");
	a_wdog_clears_en: assert property (@(posedge core_clk) disable iff (!reset_n)
		watchdog_expired && !reg_reset_cmd && !reg_wr
		|=> !conv_enable && $stable(converter_control_q[6:2]) && $stable(chan_off))
		else $error("watchdog did not clear only the enable");
	a_regrst_defaults: assert property (@(posedge core_clk) disable iff (!reset_n)
		reg_reset_cmd |=> converter_control_q == CAFM_RST_CONV_CTRL &&
		chan_off == 11'h000 && fault_irq_mask_one_q == 8'h00)
		else $error("register reset did not restore defaults");
	a_reserved_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
		converter_control_q[1:0] == 2'h0 && fault_irq_mask_one_q[3] == 1'b0 &&
		fault_irq_mask_one_q[1:0] == 2'h0 && channel_disable_zero_q[0] == 1'b0 &&
		channel_disable_one_q[3:0] == 4'h0)
		else $error("reserved bit read nonzero");
	a_done_cont_quiet: assert property (@(posedge core_clk) disable iff (!reset_n)
		pass_done && !conv_one_shot && !(|(evts[4:0] & ~blks[4:0])) |=> !irq_pulse)
		else $error("done interrupt raised in continuous mode");
	a_mean_no_discharge: assert property (@(posedge core_clk) disable iff (!reset_n)
		ibat_discharging |-> !mean_apply_ibat)
		else $error("averaging applied to discharge current");
endmodule // cafm_regs
`default_nettype wire

// File: verilog/cafm_pkg.sv
// Purpose: Constants for the charger converter control and fault mask bank.
// Assumes: Byte-wide registers reached through a byte register port.
// Notes:   Offsets are the device register addresses.
package cafm_pkg;
	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [7:0] CAFM_OFS_FAULT_MASK_ONE = 8'h2D;
	localparam logic [7:0] CAFM_OFS_CONV_CTRL      = 8'h2E;
	localparam logic [7:0] CAFM_OFS_CHAN_DIS_ZERO  = 8'h2F;
	localparam logic [7:0] CAFM_OFS_CHAN_DIS_ONE   = 8'h30;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] CAFM_RST_FAULT_MASK_ONE = 8'h00;
	localparam logic [7:0] CAFM_RST_CONV_CTRL      = 8'h30;
	localparam logic [7:0] CAFM_RST_CHAN_DIS_ZERO  = 8'h00;
	localparam logic [7:0] CAFM_RST_CHAN_DIS_ONE   = 8'h00;

	// ****************************************************************
	// Writable bit masks; other bits are reserved and read zero
	// ****************************************************************
	localparam logic [7:0] CAFM_WMASK_FAULT_ONE = 8'hF4;
	localparam logic [7:0] CAFM_WMASK_CONV_CTRL = 8'hFC;
	localparam logic [7:0] CAFM_WMASK_DIS_ZERO  = 8'hFE;
	localparam logic [7:0] CAFM_WMASK_DIS_ONE   = 8'hF0;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int CAFM_BIT_SYS_SHORT   = 7;
	localparam int CAFM_BIT_SYS_OV      = 6;
	localparam int CAFM_BIT_SRC_OV      = 5;
	localparam int CAFM_BIT_SRC_UV      = 4;
	localparam int CAFM_BIT_THERMAL     = 2;
	localparam int CAFM_BIT_CONV_EN     = 7;
	localparam int CAFM_BIT_ONE_SHOT    = 6;
	localparam int CAFM_BIT_SPEED_HI    = 5;
	localparam int CAFM_BIT_SPEED_LO    = 4;
	localparam int CAFM_BIT_MEAN        = 3;
	localparam int CAFM_BIT_SEED        = 2;
	localparam int CAFM_DIS0_LO         = 1;
	localparam int CAFM_DIS1_LO         = 4;

	// Number of fault sources in this mask register.
	localparam int CAFM_NUM_FAULTS = 5;
	// Conversion channels: seven in disable zero, four in disable one.
	localparam int CAFM_NUM_CHANS  = 11;

	// Effective resolution per sample-speed code.
	typedef enum logic [1:0] {
		CAFM_RES_15 = 2'h0,
		CAFM_RES_14 = 2'h1,
		CAFM_RES_13 = 2'h2,
		CAFM_RES_12 = 2'h3
	} cafm_res_t;
endpackage : cafm_pkg

// File: verilog/cafm_irq_gate.sv
// Purpose: Gates fault and done events onto one interrupt pulse.
// Assumes: Events are one-cycle pulses synchronous to core_clk.
// Notes:   A set mask bit blocks its source; output is registered.
`timescale 1ns/10ps
`default_nettype none
module cafm_irq_gate #(
	parameter int N = 6
) (
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         reset_n,
	// Events and masks
	input  wire logic [N-1:0] event_pulse,
	input  wire logic [N-1:0] event_block,
	// Interrupt
	output logic              irq_pulse
);
	import cafm_pkg::*;

	initial begin
		if (N < 1) $error("cafm_irq_gate needs at least one source");
	end

	// One registered pulse per cycle with any unblocked event.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			irq_pulse <= 1'b0;
		end else begin
			irq_pulse <= |(event_pulse & ~event_block);
		end
	end
endmodule // cafm_irq_gate
`default_nettype wire

// File: verilog/cafm_sample_sched.sv
// Purpose: Chooses the next enabled conversion channel in round robin.
// Assumes: Channel mask bit set means channel excluded.
// Notes:   Purely a channel pointer; conversion timing is external.
`timescale 1ns/10ps
`default_nettype none
module cafm_sample_sched #(
	parameter int NCH = 11
) (
	// Clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    reset_n,
	// Control
	input  wire logic                    run,
	input  wire logic                    step,
	input  wire logic [NCH-1:0]          chan_off,
	// Status
	output logic [$clog2(NCH)-1:0]       chan_q,
	output logic                         wrap_pulse
);
	import cafm_pkg::*;

	localparam int W = $clog2(NCH);

	initial begin
		if (NCH < 2) $error("cafm_sample_sched needs two or more channels");
	end

	// Find next enabled channel after the current one.
	function automatic logic [W:0] next_chan(input logic [W-1:0] cur,
		input logic [NCH-1:0] off);
		logic [W:0] res;
		int         idx;
		res = {1'b1, {W{1'b0}}};
		for (int k = NCH; k >= 1; k--) begin
			idx = (int'(cur) + k) % NCH;
			if (!off[idx]) begin
				res = {1'b0, W'(idx)};
			end
		end
		return res;
	endfunction

	logic [W:0] nxt;
	assign nxt = next_chan(chan_q, chan_off);

	// Pointer advances on each finished conversion; wrap ends a pass.
	always_ff @(posedge core_clk) begin
		if (!reset_n || !run) begin
			chan_q     <= '0;
			wrap_pulse <= 1'b0;
		end else begin
			wrap_pulse <= 1'b0;
			if (step && !nxt[W]) begin
				chan_q     <= nxt[W-1:0];
				wrap_pulse <= (nxt[W-1:0] <= chan_q);
			end
		end
	end
endmodule // cafm_sample_sched
`default_nettype wire

// File: sim/cafm_host_model.sv
// Purpose: Host model that drives the byte register port.
// Assumes: A write is taken at the edge where reg_wr is high.
// Notes:   Released write data shows inverted values.
`timescale 1ns/10ps
`default_nettype none
module cafm_host_model (
	// Clock
	input  wire logic  core_clk,
	// Register port
	output logic       reg_wr,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata
);
	// ********************
	// Port driving
	// ********************
	// Idle port at time zero.
	initial begin
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// Data is inverted on release so stale data never looks valid.
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		#1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge core_clk);
		#1;
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask
	// Read data is combinational, so present the address and settle.
	task automatic set_addr(input logic [7:0] a);
		@(posedge core_clk);
		#1;
		reg_addr = a;
		#2;
	endtask
endmodule // cafm_host_model
`default_nettype wire

// File: sim/testbench.sv
// Purpose: Self-checking bench for the converter control bank.
// Assumes: Integer model of the four registers kept by the bench.
// Notes:   Channel order is not checked, only pass completion and the final pointer after a continuous run.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module testbench;
	import cafm_pkg::*;
	logic core_clk, reset_n, reg_wr, reg_hit, irq_pulse, s;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic reg_reset_cmd, watchdog_expired, conv_done_evt;
	logic done_irq_block, ibat_discharging, conv_enable, conv_one_shot;
	logic running_mean_select, mean_seed_select, mean_apply_ibat;
	logic [4:0] fevt;
	cafm_res_t conv_resolution;
	logic [10:0] chan_off;
	logic [3:0] conv_chan;
	int mismatches, compares, irqs, mdl[4];
	int ofs[4] = '{CAFM_OFS_FAULT_MASK_ONE, CAFM_OFS_CONV_CTRL,
		CAFM_OFS_CHAN_DIS_ZERO, CAFM_OFS_CHAN_DIS_ONE};
	int rst[4] = '{CAFM_RST_FAULT_MASK_ONE, CAFM_RST_CONV_CTRL,
		CAFM_RST_CHAN_DIS_ZERO, CAFM_RST_CHAN_DIS_ONE};
	int wm[4] = '{CAFM_WMASK_FAULT_ONE, CAFM_WMASK_CONV_CTRL,
		CAFM_WMASK_DIS_ZERO, CAFM_WMASK_DIS_ONE};
	int fb[5] = '{7, 6, 5, 4, 2};
	// Clock at 40 MHz.
	always #12.5 core_clk = ~core_clk;
	cafm_host_model host_u (.core_clk(core_clk), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata));
	cafm_regs dut_u (.core_clk(core_clk), .reset_n(reset_n),
		.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_hit(reg_hit),
		.reg_reset_cmd(reg_reset_cmd), .watchdog_expired(watchdog_expired),
		.system_short_evt(fevt[0]), .system_overvolt_evt(fevt[1]),
		.source_overvolt_evt(fevt[2]), .source_undervolt_evt(fevt[3]),
		.thermal_trip_evt(fevt[4]), .conv_done_evt(conv_done_evt),
		.done_irq_block(done_irq_block), .ibat_discharging(ibat_discharging),
		.conv_enable(conv_enable), .conv_one_shot(conv_one_shot),
		.conv_resolution(conv_resolution),
		.running_mean_select(running_mean_select),
		.mean_seed_select(mean_seed_select),
		.mean_apply_ibat(mean_apply_ibat), .chan_off(chan_off),
		.conv_chan(conv_chan), .irq_pulse(irq_pulse));
	// ********************
	// Model and checks
	// ********************
	// Verdict; the only place the run ends.
	task automatic tally_and_finish;
		if (mismatches == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// A write lands in the model with reserved bits forced to zero.
	task automatic wr(input int i, input int d);
		host_u.write_reg(8'(ofs[i]), 8'(d));
		mdl[i] = d & wm[i];
	endtask
	// Pulse one control input for a single cycle.
	task automatic pulse(ref logic p);
		@(posedge core_clk);
		#1;
		p = 1'b1;
		@(posedge core_clk);
		#1;
		p = 1'b0;
	endtask
	// Compare every register and every control output except conv_chan with the model.
	task automatic check_all;
		for (int i = 0; i < 4; i++) begin
			host_u.set_addr(8'(ofs[i]));
			`CHK("rdata", 8'(mdl[i]), reg_rdata)
			`CHK("hit", 1'b1, reg_hit)
		end
		`CHK("enable", 1'(mdl[1] >> 7), conv_enable)
		`CHK("one_shot", 1'(mdl[1] >> 6), conv_one_shot)
		`CHK("res", 2'(mdl[1] >> 4), conv_resolution)
		`CHK("mean", 1'(mdl[1] >> 3), running_mean_select)
		`CHK("mean_ibat", 1'(((mdl[1] >> 3) & 1) && !ibat_discharging), mean_apply_ibat)
		`CHK("seed", 1'(mdl[1] >> 2), mean_seed_select)
		`CHK("chan_off", 11'(((mdl[3] >> 4) << 7) | (mdl[2] >> 1)), chan_off)
	endtask
	// Feed done pulses on alternate cycles and count interrupt cycles.
	task automatic run_conv(output int n);
		n = 0;
		for (int k = 0; k < 40; k++) begin
			@(posedge core_clk);
			#1;
			conv_done_evt = (k % 2 == 0);
			n += (irq_pulse === 1'b1);
		end
		conv_done_evt = 1'b0;
	endtask
	// A hang counts as a mismatch.
	initial begin
		repeat (100000) @(posedge core_clk);
		mismatches++;
		tally_and_finish;
	end
	// ********************
	// Main sequence
	// ********************
	initial begin
		core_clk = 0; reset_n = 0; reg_reset_cmd = 0; watchdog_expired = 0;
		conv_done_evt = 0; done_irq_block = 0; ibat_discharging = 0;
		fevt = 0; mismatches = 0; compares = 0;
		repeat (16) @(posedge core_clk);
		#1;
		reset_n = 1;
		void'($urandom(20));
		mdl = rst;
		check_all;
		// Unmapped offsets read zero and swallow writes.
		host_u.write_reg(8'h31, 8'hFF);
		host_u.set_addr(8'h31);
		`CHK("hit_unmapped", 1'b0, reg_hit)
		`CHK("rdata_unmapped", 8'h00, reg_rdata)
		for (int i = 0; i < 4; i++) wr(i, 255);
		check_all;
		repeat (12) begin
			wr($urandom_range(3, 0), $urandom_range(255, 0));
			ibat_discharging = $urandom_range(1, 0);
			check_all;
		end
		// Watchdog clears only the enable bit; soft reset restores all.
		wr(1, 'hFC);
		wr(0, 'hFF);
		pulse(watchdog_expired);
		mdl[1] &= 'h7F;
		check_all;
		pulse(reg_reset_cmd);
		mdl = rst;
		check_all;
		// Each fault with its own mask bit clear and then alone set.
		for (int k = 0; k < 5; k++) begin
			for (int m = 0; m < 2; m++) begin
				wr(0, m ? (1 << fb[k]) : ('hFF ^ (1 << fb[k])));
				@(posedge core_clk);
				#1;
				fevt = 5'(1 << k);
				@(posedge core_clk);
				#1;
				fevt = 0;
				s = irq_pulse;
				`CHK("fault_irq", 1'(m == 0), s)
			end
		end
		wr(0, 0);
		// One-shot pass ends itself and raises done unless blocked.
		for (int b = 0; b < 2; b++) begin
			done_irq_block = 1'(b);
			wr(1, 'hC0);
			run_conv(irqs);
			`CHK("done_irq", 1 - b, irqs)
			mdl[1] &= 'h7F;
			check_all;
		end
		done_irq_block = 0;
		wr(1, 'h80);
		run_conv(irqs);
		`CHK("cont_irq", 0, irqs)
		`CHK("chan_ptr", 4'(20 % CAFM_NUM_CHANS), conv_chan)
		check_all;
		tally_and_finish;
	end
endmodule // testbench
`default_nettype wire
